// file: src/slrc_pkg.sv
package slrc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SLRC_CLK_PERIOD_NS = 40;
  localparam int SLRC_RESET_MIN_US = 160;
  // Least time, so round up
  localparam int SLRC_RESET_MIN_CYC =
    (SLRC_RESET_MIN_US * 1000 + SLRC_CLK_PERIOD_NS - 1) / SLRC_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SLRC_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] SLRC_ADDR_ADVERT = 8'h04;
  localparam logic [7:0] SLRC_ADDR_STRAPS = 8'h08;
  localparam logic [7:0] SLRC_ADDR_PIN_DRIVE = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLRC_CTL_SOFT_RESET = 15;
  localparam int SLRC_CTL_SPEED_100 = 13;
  localparam int SLRC_CTL_AUTONEG_EN = 12;
  localparam int SLRC_CTL_FULL_DUPLEX = 8;
  localparam int SLRC_ADV_10_HALF = 5;
  localparam int SLRC_ADV_10_FULL = 6;
  localparam int SLRC_ADV_100_HALF = 7;
  localparam int SLRC_ADV_100_FULL = 8;
  localparam int SLRC_ADV_PAUSE = 10;
  localparam int SLRC_STRAP_MODE0 = 0;
  localparam int SLRC_STRAP_MODE1 = 1;
  localparam int SLRC_STRAP_AUTONEG_STRAP_ENABLE = 2;
  localparam int SLRC_STRAP_PAUSE = 3;
  localparam int SLRC_STRAP_LAMP_CFG = 4;
  localparam int SLRC_STAT_HW_RESET = 8;

  // ----------------------------------------------------------------
  // Values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] SLRC_ADV_SELECTOR = 16'h0001;
  localparam logic [15:0] SLRC_CTL_WR_MASK = 16'h7fff;
  localparam logic [15:0] SLRC_ADV_WR_MASK = 16'hffe0;
  // Pull-ups: every strap pin reads high when left floating
  localparam logic [4:0] SLRC_STRAP_DEFAULT = 5'h1f;
  localparam logic [3:0] SLRC_PIN_DRIVE_DEFAULT = 4'hf;

  // Basic control word from the three mode straps
  function automatic logic [15:0] slrc_ctl_from_straps(input logic [4:0] s);
    logic [15:0] c;
    c = 16'h0000;
    c[SLRC_CTL_AUTONEG_EN] = s[SLRC_STRAP_AUTONEG_STRAP_ENABLE];
    c[SLRC_CTL_SPEED_100] = s[SLRC_STRAP_MODE1];
    c[SLRC_CTL_FULL_DUPLEX] = s[SLRC_STRAP_MODE0];
    return c;
  endfunction

  // Advertisement word from mode straps and the pause strap
  function automatic logic [15:0] slrc_adv_from_straps(input logic [4:0] s);
    logic [15:0] a;
    logic [1:0] m;
    a = SLRC_ADV_SELECTOR;
    m = {s[SLRC_STRAP_MODE1], s[SLRC_STRAP_MODE0]};
    if (s[SLRC_STRAP_AUTONEG_STRAP_ENABLE])
    begin
      a[SLRC_ADV_10_HALF] = (m != 2'h1);
      a[SLRC_ADV_10_FULL] = (m == 2'h0) || (m == 2'h3);
      a[SLRC_ADV_100_HALF] = (m != 2'h0);
      a[SLRC_ADV_100_FULL] = (m == 2'h1) || (m == 2'h3);
    end
    else
    begin
      a[SLRC_ADV_10_HALF] = (m == 2'h0);
      a[SLRC_ADV_10_FULL] = (m == 2'h1);
      a[SLRC_ADV_100_HALF] = (m == 2'h2);
      a[SLRC_ADV_100_FULL] = (m == 2'h3);
    end
    // Floating pin gives 0, pulled low gives 1
    a[SLRC_ADV_PAUSE] = ~s[SLRC_STRAP_PAUSE];
    return a;
  endfunction

endpackage

// file: src/slrc_sync.sv
`timescale 1ns/1ps

module slrc_sync
  #(parameter int WIDTH = 1)
  (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
  );

  logic [WIDTH-1:0] stage1;

  // Resets to zero: a held-low reset pin reads as asserted
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// file: src/slrc_reset_qual.sv
`timescale 1ns/1ps

module slrc_reset_qual
  #(parameter int MIN_CYCLES = 4000)
  (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_high,
  output logic hw_reset_active
  );

  localparam int CW = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_CYCLES - 1);

  logic [CW-1:0] low_count;

  // Short low glitches never reach the full count and are ignored
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      low_count <= '0;
      hw_reset_active <= 1'b1;
    end
    else if (pin_high)
    begin
      low_count <= '0;
      hw_reset_active <= 1'b0;
    end
    else if (low_count == LAST)
    begin
      hw_reset_active <= 1'b1;
    end
    else
    begin
      low_count <= low_count + CW'(1);
    end
  end

endmodule

// file: src/slrc_top.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps

// Behaviour
// - Enable plus two mode straps force speed/duplex, or choose advertised abilities; default 111.
// - Strap levels are captured into control and advertisement registers during hardware reset.
// - After reset release the dual-purpose strap pins may become driven outputs.
// - Floating pause strap writes 0 into the pause advertisement bit.
// - Pause strap pulled low writes 1 into the pause advertisement bit.
// - Pause strap sampled only in reset; bit held until reset or register write.
// - Lamp configuration strap, latched at reset, sets lamp polarity and function.
// - Reset pin is active low; at least 160 us low starts a full reset.
// - Hardware reset restores all register defaults and re-samples every strap.
module slrc_top
  import slrc_pkg::*;
  #(parameter int RESET_MIN_CYCLES = SLRC_RESET_MIN_CYC)
  (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External reset pin
  input wire logic reset_pin_n,
  // Dual-purpose strap pins
  input wire logic autoneg_strap_enable_in,
  output logic autoneg_strap_enable_out,
  output logic autoneg_strap_enable_oe_n,
  input wire logic mode_strap_bit1_in,
  output logic mode_strap_bit1_out,
  output logic mode_strap_bit1_oe_n,
  input wire logic mode_strap_bit0_in,
  output logic mode_strap_bit0_out,
  output logic mode_strap_bit0_oe_n,
  input wire logic pause_strap_in,
  output logic pause_strap_out,
  output logic pause_strap_oe_n,
  input wire logic duplex_lamp_config_strap,
  // Link state from the core
  input wire logic link_up,
  input wire logic resolved_full_duplex,
  // Towards the core
  output logic [15:0] basic_control,
  output logic [15:0] advertisement,
  output logic core_reset,
  output logic full_duplex_lamp
  );

  // ----------------------------------------------------------------
  // Reset pin qualification
  // ----------------------------------------------------------------
  logic pin_sync;
  logic hw_reset_active;

  slrc_sync #(.WIDTH(1)) u_sync
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(reset_pin_n),
    .sync_out(pin_sync)
  );

  slrc_reset_qual #(.MIN_CYCLES(RESET_MIN_CYCLES)) u_qual
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_high(pin_sync),
    .hw_reset_active(hw_reset_active)
  );

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [4:0] strap_pins;
  logic [4:0] strap_latch;

  always_comb
  begin
    strap_pins = '0;
    strap_pins[SLRC_STRAP_MODE0] = mode_strap_bit0_in;
    strap_pins[SLRC_STRAP_MODE1] = mode_strap_bit1_in;
    strap_pins[SLRC_STRAP_AUTONEG_STRAP_ENABLE] = autoneg_strap_enable_in;
    strap_pins[SLRC_STRAP_PAUSE] = pause_strap_in;
    strap_pins[SLRC_STRAP_LAMP_CFG] = duplex_lamp_config_strap;
  end

  // Tracks the pins for the whole reset; the cycle in which release is
  // seen is still inside it, so that cycle gives the final sample
  // The first reset cycle may still see driven pins; later cycles overwrite it
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      strap_latch <= SLRC_STRAP_DEFAULT;
    else if (hw_reset_active)
      strap_latch <= strap_pins;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup_phase;
  logic addr_ok;
  logic access_done;
  logic wr_en;
  logic [15:0] lane_mask;
  logic [3:0] pin_drive;
  logic soft_reset_req;
  logic [31:0] next_prdata;

  assign setup_phase = psel && !penable;
  assign addr_ok = (paddr == SLRC_ADDR_CONTROL) || (paddr == SLRC_ADDR_ADVERT) ||
                   (paddr == SLRC_ADDR_STRAPS) || (paddr == SLRC_ADDR_PIN_DRIVE);
  assign access_done = psel && penable && pready;
  // Writes are dropped while the device is held in hardware reset
  assign wr_en = access_done && pwrite && !pslverr && !hw_reset_active;
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      SLRC_ADDR_CONTROL: next_prdata[15:0] = basic_control;
      SLRC_ADDR_ADVERT: next_prdata[15:0] = advertisement;
      SLRC_ADDR_STRAPS:
      begin
        next_prdata[4:0] = strap_latch;
        next_prdata[SLRC_STAT_HW_RESET] = hw_reset_active;
      end
      SLRC_ADDR_PIN_DRIVE: next_prdata[3:0] = pin_drive;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // No wait state: answer is prepared in setup, pready high in the first access cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase && !addr_ok;
      if (setup_phase)
        prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Control and advertisement registers
  // ----------------------------------------------------------------
  logic wr_control;
  logic wr_advert;
  logic wr_pin_drive;

  // Register decodes shared by the write paths
  assign wr_control = wr_en && (paddr == SLRC_ADDR_CONTROL);
  assign wr_advert = wr_en && (paddr == SLRC_ADDR_ADVERT);
  assign wr_pin_drive = wr_en && (paddr == SLRC_ADDR_PIN_DRIVE);

  // Pin reset wins over soft reset and writes, so the straps always reach the register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      basic_control <= slrc_ctl_from_straps(SLRC_STRAP_DEFAULT);
    end
    else if (hw_reset_active)
    begin
      basic_control <= slrc_ctl_from_straps(strap_pins);
    end
    else if (soft_reset_req)
    begin
      // Software reset reloads from the latch; it does not re-sample pins
      basic_control <= slrc_ctl_from_straps(strap_latch);
    end
    else if (wr_control)
    begin
      basic_control <= (basic_control & ~(lane_mask & SLRC_CTL_WR_MASK)) |
                       (pwdata[15:0] & lane_mask & SLRC_CTL_WR_MASK);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      advertisement <= slrc_adv_from_straps(SLRC_STRAP_DEFAULT);
    end
    else if (hw_reset_active)
    begin
      advertisement <= slrc_adv_from_straps(strap_pins);
    end
    else if (soft_reset_req)
    begin
      // Same latched sample as the control word, so the two stay consistent
      advertisement <= slrc_adv_from_straps(strap_latch);
    end
    else if (wr_advert)
    begin
      advertisement <= (advertisement & ~(lane_mask & SLRC_ADV_WR_MASK)) |
                       (pwdata[15:0] & lane_mask & SLRC_ADV_WR_MASK);
    end
  end

  // Self-clearing: the reset bit never stays set in the register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      soft_reset_req <= 1'b0;
    else
      soft_reset_req <= wr_control && pstrb[1] &&
                        pwdata[SLRC_CTL_SOFT_RESET];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || hw_reset_active)
      pin_drive <= SLRC_PIN_DRIVE_DEFAULT;
    else if (wr_pin_drive && pstrb[0])
      pin_drive <= pwdata[3:0];
  end

  // ----------------------------------------------------------------
  // Dual-purpose pins and core reset
  // ----------------------------------------------------------------
  // Pins stay released in reset so the strap resistors set the level;
  // turning them round a cycle after release keeps the final sample clean
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      autoneg_strap_enable_oe_n <= 1'b1;
      mode_strap_bit1_oe_n <= 1'b1;
      mode_strap_bit0_oe_n <= 1'b1;
      pause_strap_oe_n <= 1'b1;
    end
    else
    begin
      autoneg_strap_enable_oe_n <= hw_reset_active;
      mode_strap_bit1_oe_n <= hw_reset_active;
      mode_strap_bit0_oe_n <= hw_reset_active;
      pause_strap_oe_n <= hw_reset_active;
    end
  end

  // Levels driven once the pins have turned round
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      autoneg_strap_enable_out <= 1'b1;
      mode_strap_bit1_out <= 1'b1;
      mode_strap_bit0_out <= 1'b1;
      pause_strap_out <= 1'b1;
    end
    else
    begin
      autoneg_strap_enable_out <= pin_drive[SLRC_STRAP_AUTONEG_STRAP_ENABLE];
      mode_strap_bit1_out <= pin_drive[SLRC_STRAP_MODE1];
      mode_strap_bit0_out <= pin_drive[SLRC_STRAP_MODE0];
      pause_strap_out <= pin_drive[SLRC_STRAP_PAUSE];
    end
  end

  // Core held for the whole pin reset and one cycle after a soft reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      core_reset <= 1'b1;
    else
      core_reset <= hw_reset_active || soft_reset_req;
  end

  // ----------------------------------------------------------------
  // Full-duplex lamp
  // ----------------------------------------------------------------
  // Strap high: active low, shows duplex alone. Strap low: active high,
  // lit only while the link is up in full duplex
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || hw_reset_active)
      full_duplex_lamp <= SLRC_STRAP_DEFAULT[SLRC_STRAP_LAMP_CFG];
    else if (strap_latch[SLRC_STRAP_LAMP_CFG])
      full_duplex_lamp <= !resolved_full_duplex;
    else
      full_duplex_lamp <= resolved_full_duplex && link_up;
  end

endmodule

// file: verification/slrc_props.sv
`timescale 1ns/1ps

module slrc_props
  (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic autoneg_strap_enable_oe_n,
  input wire logic mode_strap_bit1_oe_n,
  input wire logic mode_strap_bit0_oe_n,
  input wire logic pause_strap_oe_n,
  input wire logic core_reset,
  input wire logic [15:0] advertisement,
  input wire logic full_duplex_lamp
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire logic apb_wr = psel && penable && pwrite;
  wire logic oe_all = autoneg_strap_enable_oe_n && mode_strap_bit1_oe_n && mode_strap_bit0_oe_n
    && pause_strap_oe_n;
  wire logic oe_none = !(autoneg_strap_enable_oe_n || mode_strap_bit1_oe_n
    || mode_strap_bit0_oe_n || pause_strap_oe_n);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  oe_in_reset_a: assert property (core_reset && $past(core_reset) |-> oe_all)
    else $error("strap pin driven during reset");
  oe_on_release_a: assert property ($fell(core_reset) |-> oe_none)
    else $error("strap pins not driven after reset");
  apb_answer_a: assert property (psel && !penable |=> pready
    && pslverr == ($past(paddr) > 8'h0c || $past(paddr[1:0]) != 2'h0))
    else $error("setup not answered in the next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  selector_fixed_a: assert property (advertisement[4:0] == 5'h01)
    else $error("advertisement selector field wrong");
  pause_held_a: assert property (!core_reset && !$past(core_reset) && !$past(apb_wr)
    && !$past(apb_wr, 2) |-> $stable(advertisement[10]))
    else $error("pause bit changed outside reset and writes");
  lamp_in_reset_a: assert property (core_reset && $past(core_reset) |-> full_duplex_lamp)
    else $error("lamp not forced during reset");
endmodule

// file: verification/slrc_board.sv
`timescale 1ns/1ps

module slrc_board
  (
  input wire logic ref_clk,
  input wire logic [4:0] pull_down,
  input wire logic [3:0] drv_out,
  input wire logic [3:0] drv_oe_n,
  output logic [3:0] pin,
  output logic lamp_cfg,
  output logic reset_pin_n
  );
  // Pin order follows PIN_DRIVE: mode0, mode1, autoneg enable, pause.
  // Resistive straps, so the device may override them once out of reset.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pin[i] = drv_oe_n[i] ? ~pull_down[i] : drv_out[i];
  end
  assign lamp_cfg = ~pull_down[4];
  initial reset_pin_n = 1'b1;
  task automatic hold_reset(input int n);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    reset_pin_n <= 1'b1;
  endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import slrc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic link_up = 1'b0;
  logic resolved_full_duplex = 1'b0;
  logic [4:0] pull_down = 5'h00;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, core_reset, full_duplex_lamp, lamp_cfg, reset_pin_n;
  logic [3:0] pin, drv, oe_n;
  logic [15:0] basic_control, advertisement;
  int miscompares = 0;
  int checks = 0;
  // Advertised abilities 100F..10H by {autoneg, mode1, mode0}
  localparam logic [3:0] ADV_TAB [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h5, 4'hf};
  initial forever #20 ref_clk = ~ref_clk;
  slrc_top #(.RESET_MIN_CYCLES(8)) dut
    (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n),
    .autoneg_strap_enable_in(pin[2]), .autoneg_strap_enable_out(drv[2]),
    .autoneg_strap_enable_oe_n(oe_n[2]), .mode_strap_bit1_in(pin[1]),
    .mode_strap_bit1_out(drv[1]), .mode_strap_bit1_oe_n(oe_n[1]),
    .mode_strap_bit0_in(pin[0]), .mode_strap_bit0_out(drv[0]),
    .mode_strap_bit0_oe_n(oe_n[0]), .pause_strap_in(pin[3]), .pause_strap_out(drv[3]),
    .pause_strap_oe_n(oe_n[3]), .duplex_lamp_config_strap(lamp_cfg), .link_up(link_up),
    .resolved_full_duplex(resolved_full_duplex), .basic_control(basic_control),
    .advertisement(advertisement), .core_reset(core_reset),
    .full_duplex_lamp(full_duplex_lamp));
  slrc_board board
    (.ref_clk(ref_clk), .pull_down(pull_down), .drv_out(drv), .drv_oe_n(oe_n), .pin(pin),
    .lamp_cfg(lamp_cfg), .reset_pin_n(reset_pin_n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] ctl_of(input logic [4:0] s);
    return {18'h0, s[1], s[2], 3'h0, s[0], 8'h00};
  endfunction
  function automatic logic [31:0] adv_of(input logic [4:0] s);
    return {21'h0, ~s[3], 1'b0, ADV_TAB[s[2:0]], 5'h01};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1);
    // No wait state: the answer stands in the first access cycle
    cmp(32'(n), 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns in this time step
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rdat, e);
  endtask
  task automatic restrap(input logic [4:0] pd, input int len);
    pull_down <= pd;
    @(posedge ref_clk);
    board.hold_reset(len);
    // Two sync stages, release, then pin drive: eight is ample
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(SLRC_ADDR_CONTROL, 32'h3100);
    rd(SLRC_ADDR_ADVERT, 32'h01e1);
    for (int v = 0; v < 32; v++)
    begin
      {link_up, resolved_full_duplex} <= v[1:0];
      restrap(5'(v), 10);
      rd(SLRC_ADDR_CONTROL, ctl_of(~5'(v)));
      rd(SLRC_ADDR_ADVERT, adv_of(~5'(v)));
      rd(SLRC_ADDR_STRAPS, {27'h0, ~5'(v)});
      cmp({16'h0, basic_control}, ctl_of(~5'(v)));
      cmp({16'h0, advertisement}, adv_of(~5'(v)));
      cmp({24'h0, oe_n, pin}, 32'h0f);
      cmp({31'h0, full_duplex_lamp}, {31'h0, (v[4] ? v[0] && v[1] : !v[0])});
    end
    fork
      board.hold_reset(24);
      begin
        repeat (14) @(posedge ref_clk);
        apb(1'b1, SLRC_ADDR_ADVERT, 32'h0);
        rd(SLRC_ADDR_STRAPS, 32'h100);
      end
    join
    repeat (8) @(posedge ref_clk);
    rd(SLRC_ADDR_ADVERT, 32'h0421);
    apb(1'b1, SLRC_ADDR_ADVERT, 32'h01e0);
    restrap(5'h00, 4);
    rd(SLRC_ADDR_ADVERT, 32'h01e1);
    rd(SLRC_ADDR_CONTROL, 32'h0000);
    apb(1'b1, SLRC_ADDR_PIN_DRIVE, 32'h5);
    @(posedge ref_clk);
    cmp({28'h0, pin}, 32'h5);
    apb(1'b1, SLRC_ADDR_STRAPS, 32'h1f);
    rd(SLRC_ADDR_STRAPS, 32'h0);
    apb(1'b1, SLRC_ADDR_CONTROL, 32'h8000);
    rd(SLRC_ADDR_ADVERT, 32'h0421);
    rd(8'h10, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    end_of_test();
  end
endmodule

bind slrc_top slrc_props props
  (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .autoneg_strap_enable_oe_n, .mode_strap_bit1_oe_n, .mode_strap_bit0_oe_n,
  .pause_strap_oe_n, .core_reset, .advertisement, .full_duplex_lamp);
